// ---- logic/vds_serializer.sv ----
// video dot serializer: text, block graphics and high-res dot paths
`timescale 1ns/1ps
`default_nettype none
module vds_serializer (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        cell_load_strobe,
  input  wire logic [7:0]  char_byte,
  input  wire logic [3:0]  row_count,
  input  wire logic [6:0]  char_pos,
  input  wire logic [4:0]  char_line,
  input  wire logic        access_window_block,
  input  wire logic        high_resolution_load_inhibit_n,
  input  wire logic [5:0]  high_resolution_data,
  input  wire logic [4:0]  cg_row_dots,
  input  wire logic        port_write,
  input  wire logic [7:0]  port_addr,
  input  wire logic [7:0]  port_data,
  input  wire logic        horizontal_timing_pulse,
  input  wire logic        vertical_timing_pulse,
  output var  logic [10:0] cg_addr,
  output var  logic        text_dot,
  output var  logic        gfx_dot,
  output var  logic        high_resolution_dot_video,
  output var  logic        combined_video_n,
  output var  logic        composite_sync,
  output var  logic        screen_invert,
  output var  logic [8:0]  scan_line,
  output var  logic        frame_start
);
  localparam int W = vds_pkg::DOTS_PER_CELL;

  logic [7:0] dly_char_reg;
  logic [3:0] dly_row_reg;
  logic [5:0] dly_high_resolution_reg;
  logic       border_blank_n;
  logic       high_resolution_border_blank_n;
  logic       dly_high_resolution_inh_n_reg;
  logic       load_d1_reg;
  logic       h_prev_reg;
  logic       graphics_cell_flag;
  logic       lower_rows_blank_n;
  logic       row_bit_weight4;
  logic       row_bit_weight8;
  logic       text_ok;
  logic       gfx_ok;
  logic       high_resolution_ok;
  logic       gfx_first;
  logic       gfx_second;
  logic [W-1:0] text_word;
  logic [W-1:0] gfx_word;
  logic [W-1:0] high_resolution_word;
  logic       h_rise;

  // capture character, row and qualifiers in one step
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dly_char_reg         <= 8'h00;
      dly_row_reg          <= 4'h0;
      dly_high_resolution_reg        <= 6'h00;
      border_blank_n       <= 1'b0;
      high_resolution_border_blank_n <= 1'b0;
      dly_high_resolution_inh_n_reg  <= 1'b0;
    end else if (cell_load_strobe) begin
      dly_char_reg         <= char_byte;
      dly_row_reg          <= row_count;
      dly_high_resolution_reg        <= high_resolution_data;
      border_blank_n       <= (char_pos < vds_pkg::TEXT_COLS) &&
                              (char_line < vds_pkg::DISPLAY_LINES);
      high_resolution_border_blank_n <= (char_pos < vds_pkg::HIGH_RESOLUTION_COLS) &&
                              (char_line < vds_pkg::DISPLAY_LINES);
      dly_high_resolution_inh_n_reg  <= high_resolution_load_inhibit_n;
    end
  end

  // character generator address and load timing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cg_addr     <= 11'h000;
      load_d1_reg <= 1'b0;
    end else begin
      if (cell_load_strobe) begin
        cg_addr <= {char_byte[6:0], row_count};
      end
      load_d1_reg <= cell_load_strobe;
    end
  end

  assign graphics_cell_flag = dly_char_reg[vds_pkg::GFX_FLAG_BIT];
  assign row_bit_weight4    = dly_row_reg[vds_pkg::ROW_W4_BIT];
  assign row_bit_weight8    = dly_row_reg[vds_pkg::ROW_W8_BIT];
  assign lower_rows_blank_n = ~row_bit_weight8;

  // load qualifiers: any one low condition blocks its register
  assign text_ok  = lower_rows_blank_n & border_blank_n & ~graphics_cell_flag &
                    ~access_window_block;
  assign gfx_ok   = border_blank_n & graphics_cell_flag &
                    ~access_window_block;
  assign high_resolution_ok = high_resolution_border_blank_n & dly_high_resolution_inh_n_reg &
                    ~access_window_block;

  // dual four-to-one rectangle pair select
  always_comb begin
    gfx_first  = 1'b0;
    gfx_second = 1'b0;
    case ({row_bit_weight8, row_bit_weight4})
      2'b00: begin
        gfx_first  = dly_char_reg[0];
        gfx_second = dly_char_reg[1];
      end
      2'b01: begin
        gfx_first  = dly_char_reg[2];
        gfx_second = dly_char_reg[3];
      end
      2'b10: begin
        gfx_first  = dly_char_reg[4];
        gfx_second = dly_char_reg[5];
      end
      default: begin
        gfx_first  = 1'b0;
        gfx_second = 1'b0;
      end
    endcase
  end

  // parallel words; blocked loads push dark dots
  assign text_word  = text_ok ? {cg_row_dots, 1'b0} : '0;
  assign gfx_word   = gfx_ok ? {{vds_pkg::GROUP_DOTS{gfx_first}},
                                {vds_pkg::GROUP_DOTS{gfx_second}}} : '0;
  assign high_resolution_word = high_resolution_ok ? dly_high_resolution_reg : '0;

  vds_shift #(.W(W)) u_text (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .load      (load_d1_reg),
    .load_word (text_word),
    .dot       (text_dot)
  );

  vds_shift #(.W(W)) u_gfx (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .load      (load_d1_reg),
    .load_word (gfx_word),
    .dot       (gfx_dot)
  );

  vds_shift #(.W(W)) u_high_resolution (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .load      (load_d1_reg),
    .load_word (high_resolution_word),
    .dot       (high_resolution_dot_video)
  );

  // inversion control from the output port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      screen_invert <= vds_pkg::INVERT_RESET;
    end else if (port_write && (port_addr == vds_pkg::INVERT_PORT)) begin
      screen_invert <= port_data[vds_pkg::INVERT_BIT];
    end
  end

  // combined video, active low, optionally complemented
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      combined_video_n <= 1'b1;
    end else begin
      combined_video_n <= ~(text_dot | gfx_dot | high_resolution_dot_video) ^ screen_invert;
    end
  end

  // composite sync mix
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      composite_sync <= 1'b0;
    end else begin
      composite_sync <= horizontal_timing_pulse ^ vertical_timing_pulse;
    end
  end

  assign h_rise = horizontal_timing_pulse & ~h_prev_reg;

  // scan line counter across the frame
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      h_prev_reg  <= 1'b0;
      scan_line   <= 9'h000;
      frame_start <= 1'b0;
    end else begin
      h_prev_reg  <= horizontal_timing_pulse;
      frame_start <= 1'b0;
      if (h_rise) begin
        if (scan_line == vds_pkg::FRAME_LINES - 9'h001) begin
          scan_line   <= 9'h000;
          frame_start <= 1'b1;
        end else begin
          scan_line <= scan_line + 9'h001;
        end
      end
    end
  end

  // checks on the dot paths, inversion, sync, line count and cell sampling
  sequence s_text_dark6;
    !text_dot [*6];
  endsequence

  sequence s_gfx_dark6;
    !gfx_dot [*6];
  endsequence

  sequence s_gfx_groups;
    (gfx_dot == $past(gfx_first, 1)) ##1 (gfx_dot == $past(gfx_first, 2)) ##1
    (gfx_dot == $past(gfx_first, 3)) ##1 (gfx_dot == $past(gfx_second, 4)) ##1
    (gfx_dot == $past(gfx_second, 5)) ##1 (gfx_dot == $past(gfx_second, 6));
  endsequence

  AST_TEXT_LOWER_ROWS: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && row_bit_weight8 && !graphics_cell_flag |=> s_text_dark6)
    else $error("text dots lit in rows 8 to 11");

  AST_TEXT_SIXTH_DARK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && text_ok |-> ##6 !text_dot)
    else $error("sixth text dot lit");

  AST_GFX_GROUPS: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && gfx_ok |=> s_gfx_groups)
    else $error("graphics dot groups wrong");

  AST_GFX_ROW_SELECT: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && gfx_ok && (dly_row_reg[3:2] == 2'b10) |=>
    gfx_dot == $past(dly_char_reg[4]))
    else $error("rows 8 to 11 did not show cell bit 4");

  AST_GFX_ALPHA_DARK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && !graphics_cell_flag |=> s_gfx_dark6)
    else $error("graphics dots for alphanumeric cell");

  AST_ACCESS_BLOCK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && access_window_block |=> (!text_dot && !gfx_dot && !high_resolution_dot_video) [*6])
    else $error("load during video access");

  AST_BORDER_BLANK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && !border_blank_n |=> s_text_dark6 and s_gfx_dark6)
    else $error("text or graphics dots in the border");

  AST_HIGH_RESOLUTION_BLANK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && (!high_resolution_border_blank_n || !dly_high_resolution_inh_n_reg) |=> !high_resolution_dot_video [*6])
    else $error("high-res dots while blanked or inhibited");

  AST_INVERT_SET: assert property (@(posedge mclk) disable iff (!reset_n)
    port_write && (port_addr == vds_pkg::INVERT_PORT) && port_data[0] |=>
    screen_invert ##1 (combined_video_n == $past(text_dot | gfx_dot | high_resolution_dot_video)))
    else $error("inversion not applied");

  AST_PLAIN_VIDEO: assert property (@(posedge mclk) disable iff (!reset_n)
    !screen_invert && (text_dot || gfx_dot || high_resolution_dot_video) |=> !combined_video_n)
    else $error("lit dot not passed through");

  AST_SYNC_MIX: assert property (@(posedge mclk) disable iff (!reset_n)
    horizontal_timing_pulse && vertical_timing_pulse |=> !composite_sync)
    else $error("sync mix is not exclusive-or");

  AST_FRAME_WRAP: assert property (@(posedge mclk) disable iff (!reset_n)
    h_rise && (scan_line == 9'h105) |=> frame_start && (scan_line == 9'h000))
    else $error("frame did not wrap after 262 lines");

  AST_SAMPLE_ROW: assert property (@(posedge mclk) disable iff (!reset_n)
    cell_load_strobe |=> (dly_row_reg == $past(row_count)) &&
    (dly_char_reg == $past(char_byte)))
    else $error("cell data not sampled with strobe");

  // checks on load words, inversion, sync and line count
  AST_TEXT_WORD: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && text_ok |=>
    text_dot == $past(cg_row_dots[4]))
    else $error("first text dot not from character row");

  AST_GFX_FLAG_TEXT_DARK: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && graphics_cell_flag |=> s_text_dark6)
    else $error("text dots for graphics cell");

  AST_GFX_ROW_TOP: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && gfx_ok && (dly_row_reg[3:2] == 2'b00) |=>
    gfx_dot == $past(dly_char_reg[0]))
    else $error("rows 0 to 3 did not show cell bit 0");

  AST_HIGH_RESOLUTION_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    load_d1_reg && high_resolution_ok |=>
    high_resolution_dot_video == $past(dly_high_resolution_reg[5]))
    else $error("high-res word not loaded");

  AST_INVERT_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
    port_write && (port_addr == vds_pkg::INVERT_PORT) && !port_data[0] |=>
    !screen_invert)
    else $error("inversion not cleared");

  AST_INVERT_VIDEO: assert property (@(posedge mclk) disable iff (!reset_n)
    screen_invert && (text_dot || gfx_dot || high_resolution_dot_video) |=>
    combined_video_n)
    else $error("lit dot not complemented");

  AST_SYNC_SINGLE: assert property (@(posedge mclk) disable iff (!reset_n)
    horizontal_timing_pulse != vertical_timing_pulse |=> composite_sync)
    else $error("single sync pulse not passed");

  AST_FRAME_STEP: assert property (@(posedge mclk) disable iff (!reset_n)
    h_rise && (scan_line != 9'h105) |=>
    scan_line == $past(scan_line) + 9'h001)
    else $error("scan line did not advance");
endmodule : vds_serializer
`default_nettype wire

// ---- logic/vds_pkg.sv ----
// constants shared by the video dot serializer
// Contract
// - graphics pair selection uses row count bits of weight 4 and 8
// - rows 0-3 show bits 0,1; rows 4-7 bits 2,3; rows 8-11 bits 4,5
// - graphics line emits two 3-dot groups, each lit by one rectangle bit
// - bit 7 of delayed byte set marks graphics cell, clear marks alphanumeric
// - graphics register loads only graphics cells and keeps rows 8-11 visible
// - text, graphics and high-res registers load a word and shift dots out
// - any single unmet text qualifying condition blocks the text load
// - alphanumeric cells have rows 8 through 11 blanked
// - text and graphics blank beyond position 64 and below line 16
// - text and graphics do not load during processor video access
// - text register takes five dots; sixth dot is always dark
// - high-res register blanks past extended region and below line 16
// - high-res has its own load inhibit plus the common access block
// - port 0xFE write with bit 0 set turns on full-screen inversion
// - with inversion off the combined video passes unchanged
// - horizontal and vertical sync are mixed by exclusive-or
// - frame holds 262 scan lines at a 60 Hz refresh
// - characters are 5 by 7 dots, row picked by the row count
`default_nettype none
package vds_pkg;
  localparam int        DOTS_PER_CELL  = 6;
  localparam int        TEXT_DOTS      = 5;
  localparam int        GROUP_DOTS     = 3;
  localparam int        ROW_W4_BIT     = 2;
  localparam int        ROW_W8_BIT     = 3;
  localparam int        GFX_FLAG_BIT   = 7;
  localparam int        INVERT_BIT     = 0;
  localparam logic [7:0] INVERT_PORT   = 8'hFE;
  localparam logic [6:0] TEXT_COLS     = 7'h40;
  localparam logic [6:0] HIGH_RESOLUTION_COLS    = 7'h50;
  localparam logic [4:0] DISPLAY_LINES = 5'h10;
  localparam logic [8:0] FRAME_LINES   = 9'h106;
  localparam int        REFRESH_HZ     = 60;
  localparam logic      INVERT_RESET   = 1'b0;
endpackage : vds_pkg
`default_nettype wire

// ---- logic/vds_shift.sv ----
// parallel-load serial dot shift register
`timescale 1ns/1ps
`default_nettype none
module vds_shift #(
  parameter int W = 6
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_word,
  output var  logic         dot
);
  logic [W-1:0] shift_reg;

  // load a word or shift one dot per clock, dark fill behind
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= '0;
    end else if (load) begin
      shift_reg <= load_word;
    end else begin
      shift_reg <= {shift_reg[W-2:0], 1'b0};
    end
  end

  assign dot = shift_reg[W-1];
endmodule : vds_shift
`default_nettype wire

// ---- logic/vds_shift_unused_guard.sv ----
// no logic here: the dot shift register is the vds_shift module
`default_nettype none
`default_nettype wire

// ---- sim/vds_chargen.sv ----
// character generator model on the far side of the serializer
`timescale 1ns/1ps
`default_nettype none
module vds_chargen (
  input  wire logic [10:0] cg_addr,
  output var  logic [4:0]  cg_row_dots
);
  // five-dot row pattern from character code and row count
  always_comb begin
    cg_row_dots = cg_addr[8:4] ^ {1'b0, cg_addr[3:0]};
  end
endmodule : vds_chargen
`default_nettype wire

// ---- sim/tb_vds_serializer.sv ----
// self-checking bench for the video dot serializer
`timescale 1ns/1ps
`default_nettype none
module tb_vds_serializer;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        strobe = 1'b0;
  logic        acc = 1'b0;
  logic        inh_n = 1'b1;
  logic        pw = 1'b0;
  logic        hs = 1'b0;
  logic        vs = 1'b0;
  logic [7:0]  ch = 8'h00;
  logic [7:0]  pa = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic [3:0]  row = 4'h0;
  logic [6:0]  pos = 7'h00;
  logic [4:0]  cline = 5'h00;
  logic [5:0]  hd = 6'h00;
  logic [4:0]  rom;
  logic [10:0] cg_addr;
  logic        text_dot, gfx_dot, hi_dot, comb_n, csync, inv, fstart, inv_exp;
  logic [8:0]  scan_line;
  int          miscompares = 0;
  int          checked = 0;
  int          frames = 0;
  // blanking corner table: position, line, access, high_resolution inhibit
  logic [6:0]  tp [7] = '{7'h3F, 7'h40, 7'h4F, 7'h50, 7'h00, 7'h00, 7'h00};
  logic [4:0]  tl [7] = '{5'h0F, 5'h00, 5'h00, 5'h00, 5'h10, 5'h00, 5'h00};
  logic        ta [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
  logic        ti [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};

  vds_serializer i_vds_serializer (
    .mclk(mclk), .reset_n(reset_n), .cell_load_strobe(strobe), .char_byte(ch),
    .row_count(row), .char_pos(pos), .char_line(cline), .access_window_block(acc),
    .high_resolution_load_inhibit_n(inh_n), .high_resolution_data(hd), .cg_row_dots(rom),
    .port_write(pw), .port_addr(pa), .port_data(pd), .horizontal_timing_pulse(hs),
    .vertical_timing_pulse(vs), .cg_addr(cg_addr), .text_dot(text_dot),
    .gfx_dot(gfx_dot), .high_resolution_dot_video(hi_dot), .combined_video_n(comb_n),
    .composite_sync(csync), .screen_invert(inv), .scan_line(scan_line),
    .frame_start(fstart));
  vds_chargen i_vds_chargen (.cg_addr(cg_addr), .cg_row_dots(rom));

  // 200 MHz clock and frame pulse tally
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (fstart === 1'b1) frames++;

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one cell: strobe, then six dots and the combined video behind them
  task automatic run_cell(input logic [7:0] c, input logic [3:0] r, input logic [6:0] p,
                          input logic [4:0] l, input logic a, input logic ih);
    logic [5:0] et, eg, eh;
    logic       prev;
    et = (!c[7] && r < 8 && p < 64 && l < 16 && !a) ? {c[4:0] ^ {1'b0, r}, 1'b0} : 6'h00;
    eg = (c[7] && r < 12 && p < 64 && l < 16 && !a) ?
         {{3{c[{r[3:2], 1'b0}]}}, {3{c[{r[3:2], 1'b1}]}}} : 6'h00;
    eh = (p < 80 && l < 16 && ih && !a) ? 6'h2D : 6'h00;
    prev = 1'b0;
    @(posedge mclk);
    strobe <= 1'b1;
    ch <= c;
    row <= r;
    pos <= p;
    cline <= l;
    acc <= a;
    inh_n <= ih;
    hd <= 6'h2D;
    @(posedge mclk);
    strobe <= 1'b0;
    @(posedge mclk);
    acc <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      #1;
      if (i > 0) check(9'(comb_n), {8'h00, ~(prev ^ inv_exp)});
      if (i == 0) check(9'(cg_addr[10:4]), 9'(c[6:0]));
      if (i == 0) check(9'(cg_addr[3:0]), 9'(r));
      if (i < 6) begin
        check(9'(text_dot), 9'(et[5]));
        check(9'(gfx_dot), 9'(eg[5]));
        check(9'(hi_dot), 9'(eh[5]));
      end
      prev = et[5] | eg[5] | eh[5];
      et = et << 1;
      eg = eg << 1;
      eh = eh << 1;
      @(posedge mclk);
    end
  endtask : run_cell

  task automatic port(input logic [7:0] a, input logic [7:0] d, input logic e);
    @(posedge mclk);
    pw <= 1'b1;
    pa <= a;
    pd <= d;
    @(posedge mclk);
    pw <= 1'b0;
    #1;
    check(9'(inv), 9'(e));
    inv_exp = e;
  endtask : port

  task automatic sync(input logic h, input logic v);
    @(posedge mclk);
    hs <= h;
    vs <= v;
    @(posedge mclk);
    #1;
    check(9'(csync), 9'(h ^ v));
  endtask : sync

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    inv_exp = 1'b0;
    @(posedge mclk);
    #1;
    check({2'h0, fstart, text_dot, gfx_dot, hi_dot, comb_n, inv, csync}, 9'h004);
    check(scan_line, 9'h000);
    check(9'(cg_addr), 9'h000);
    @(posedge mclk);
    reset_n <= 1'b1;
    $display("reset test done");
    for (int r = 0; r < 13; r++) begin
      run_cell(8'hA6, 4'(r), 7'h00, 5'h00, 1'b0, 1'b1);
      run_cell(8'h2B, 4'(r), 7'h00, 5'h00, 1'b0, 1'b1);
    end
    $display("row test done");
    for (int k = 0; k < 7; k++) begin
      run_cell(8'h95, 4'h4, tp[k], tl[k], ta[k], ti[k]);
      run_cell(8'h15, 4'h4, tp[k], tl[k], ta[k], ti[k]);
    end
    $display("blanking test done");
    port(8'hFD, 8'h01, 1'b0);
    port(8'hFE, 8'h01, 1'b1);
    run_cell(8'h15, 4'h1, 7'h00, 5'h00, 1'b0, 1'b1);
    port(8'hFE, 8'hFE, 1'b0);
    run_cell(8'h15, 4'h1, 7'h00, 5'h00, 1'b0, 1'b1);
    $display("inverse test done");
    sync(1'b0, 1'b1);
    sync(1'b1, 1'b1);
    sync(1'b1, 1'b0);
    sync(1'b0, 1'b0);
    for (int n = 2; n < 264; n++) begin
      sync(1'b1, 1'b0);
      sync(1'b0, 1'b0);
      check(scan_line, 9'(n % 262));
    end
    check(9'(frames), 9'h001);
    $display("sync test done");
    summarize();
  end
endmodule : tb_vds_serializer
`default_nettype wire
